// file: dv/cgst_host_model.sv
// Purpose: host that writes and reads 16-bit control words
// Assumes: signals change just after a rising edge
// Notes:   idle write data shows the inverse of the last word
`timescale 1ns/1ps
module cgst_host_model (
  // clock
  input  wire         clk,
  // control port
  output logic [3:0]  host_addr,
  output logic        host_wr,
  output logic [15:0] host_wdata,
  output logic        host_rd,
  input  wire  [15:0] host_rdata,
  input  wire         host_rvalid
);
  initial begin
    host_addr = 4'h0;
    host_wr = 1'b0;
    host_wdata = 16'h0000;
    host_rd = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wr <= 1'b1;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask

  // answer is registered, so it is read just after the next edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    ok = host_rvalid;
    d = host_rdata;
  endtask
endmodule // cgst_host_model

// file: dv/cgst_top_assertions.sv
// Purpose: port-level checks for the gain stage and sample NCO
// Assumes: one clock, synchronous active-high reset
// Notes:   shadows a few control fields from host writes
`timescale 1ns/1ps
module cgst_assertions #(
  parameter DATA_W = 16
) (
  // clock and reset
  input wire              clk,
  input wire              sys_rst,
  // host port
  input wire [3:0]        host_addr,
  input wire              host_wr,
  input wire [15:0]       host_wdata,
  input wire              host_rd,
  input wire [15:0]       host_rdata,
  input wire              host_rvalid,
  // streams and timing
  input wire              din_valid,
  input wire [DATA_W-1:0] din_i,
  input wire [DATA_W-1:0] din_q,
  input wire              dout_valid,
  input wire [DATA_W-1:0] dout_i,
  input wire [DATA_W-1:0] dout_q,
  input wire              sample_clk,
  input wire              sample_tick,
  input wire [3:0]        coarse_phase,
  input wire              leap_carry,
  input wire              leap_precarry
);
  // ====
  // shadow fields
  logic [1:0] ip_reg;
  logic       en_reg;
  logic [2:0] sh_reg;
  wire        mapped = host_addr inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hD};

  always @(posedge clk) begin
    if (sys_rst) begin
      ip_reg <= 2'h0;
      en_reg <= 1'b0;
      sh_reg <= 3'h7;
    end else if (host_wr && host_addr == 4'hD) begin
      ip_reg <= host_wdata[1:0];
      en_reg <= host_wdata[12];
    end else if (host_wr && host_addr == 4'hA) begin
      sh_reg <= host_wdata[14:12];
    end
  end

  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_read_answer:
    assert property (host_rd |=> host_rvalid) else $error("read not answered");
  a_unmapped_zero:
    assert property (host_rd && !mapped |=> host_rdata == 16'h0000) else $error("unmapped read");
  a_gain_latency:
    assert property (din_valid |-> ##2 dout_valid) else $error("gain latency wrong");
  a_iq_same:
    assert property (dout_valid && $past(din_i, 2) == $past(din_q, 2) |-> dout_i == dout_q)
      else $error("i and q scaled differently");
  a_shift_floor:
    assert property ((sh_reg == 3'h0) [*3] ##0 dout_valid |->
      $signed(dout_i) >= -8 && $signed(dout_i) < 8) else $error("shift code 0 too loud");
  a_tick_edge:
    assert property (sample_tick |-> sample_clk && !$past(sample_clk)) else $error("bad tick");
  a_coarse_x4:
    assert property ((ip_reg == 2'h0) [*3] |-> coarse_phase[3:2] == 2'h0)
      else $error("coarse bits beyond factor");
  a_leap_off:
    assert property (!en_reg [*3] |-> !leap_carry) else $error("carry while disabled");
  a_precarry_lead:
    assert property (leap_carry |-> $past(leap_precarry)) else $error("no precarry");

  c_carry: cover property (leap_carry);
  c_tick: cover property (sample_tick);
  c_gain: cover property (dout_valid && dout_i != dout_q);
endmodule // cgst_assertions

bind cgst_top cgst_assertions #(.DATA_W(DATA_W)) cgst_assertions_inst (
  .clk, .sys_rst, .host_addr, .host_wr, .host_wdata, .host_rd, .host_rdata,
  .host_rvalid, .din_valid, .din_i, .din_q, .dout_valid, .dout_i, .dout_q,
  .sample_clk, .sample_tick, .coarse_phase, .leap_carry, .leap_precarry
);

// file: dv/cgst_top_test.sv
// Purpose: self-checking bench for the gain stage and sample NCO
// Assumes: the host model owns the control port
// Notes:   expectations come from field layouts, not the design
`timescale 1ns/1ps
module cgst_top_test;
  // ====
  // signals
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        din_valid = 1'b0;
  logic [15:0] din_i = 16'h0000;
  logic [15:0] din_q = 16'h0000;
  wire  [3:0]  host_addr, coarse_phase;
  wire  [15:0] host_wdata, host_rdata, dout_i, dout_q, fine_phase;
  wire         host_wr, host_rd, host_rvalid, dout_valid, sample_clk;
  wire         sample_tick, coarse_tick, leap_carry, leap_precarry;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          i, n;
  logic [15:0] rv;
  logic        ok;
  logic [3:0]  ra [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hD, 4'hF};

  always #2 clk = ~clk;

  cgst_top cgst_top_inst (
    .clk, .sys_rst, .host_addr, .host_wr, .host_wdata, .host_rd, .host_rdata,
    .host_rvalid, .din_valid, .din_i, .din_q, .dout_valid, .dout_i, .dout_q,
    .sample_clk, .sample_tick, .coarse_phase, .coarse_tick, .fine_phase,
    .leap_carry, .leap_precarry
  );
  cgst_host_model cgst_host_model_inst (
    .clk, .host_addr, .host_wr, .host_wdata, .host_rd, .host_rdata, .host_rvalid
  );

  // ====
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic ticks(output int c);
    c = 0;
    repeat (64) begin
      step(1);
      c += (sample_tick === 1'b1);
    end
  endtask

  function automatic logic [15:0] gexp(logic signed [15:0] x, logic [11:0] m, int s);
    logic signed [31:0] p;
    p = (x * $signed({1'b0, m})) >>> 12;
    p = p >>> ((s == 0) ? 12 : (s == 1) ? 8 : (s == 2) ? 5 : 7 - s);
    return p[15:0];
  endfunction

  task automatic gchk(input logic [15:0] x, input logic [15:0] y, input int s);
    @(posedge clk);
    din_valid <= 1'b1;
    din_i <= x;
    din_q <= y;
    @(posedge clk);
    din_valid <= 1'b0;
    din_i <= ~x;
    din_q <= ~y;
    step(1);
    chk({dout_valid, dout_i, dout_q}, {1'b1, gexp(x, 12'hFFF >> s, s), gexp(y, 12'hFFF >> s, s)});
  endtask

  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ====
  // tests
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 9; i++) begin
      cgst_host_model_inst.rd(ra[i], rv, ok);
      chk({ok, rv}, {1'b1, (ra[i] == 4'hA) ? 16'h7FFF : 16'h0000});
    end
    // accumulator still at zero, so only the offset shows
    for (i = 0; i < 4; i++) begin
      cgst_host_model_inst.wr(4'hD, {4'h0, i[1:0], 10'h002});
      step(3);
      chk({sample_clk, coarse_phase}, {i[1], i[0], 3'h0});
    end
    for (i = 0; i < 8; i++) begin
      cgst_host_model_inst.wr(4'hA, {1'b0, i[2:0], 12'hFFF >> i});
      cgst_host_model_inst.rd(4'hA, rv, ok);
      chk(rv, {1'b0, i[2:0], 12'hFFF >> i});
      gchk(16'h7123, 16'h8ACE, i);
      gchk(16'h9001, 16'h9001, i);
    end
    cgst_host_model_inst.wr(4'hD, 16'h0002);
    cgst_host_model_inst.wr(4'h4, 16'h1000);
    cgst_host_model_inst.wr(4'h5, 16'h0000);
    cgst_host_model_inst.wr(4'h6, 16'h0000);
    step(2);
    n = coarse_phase;
    step(1);
    chk(coarse_phase, (n + 2) % 16);
    chk(coarse_tick, 1'b1);
    ticks(n);
    chk(n, 4);
    cgst_host_model_inst.wr(4'h4, 16'h2000);
    ticks(n);
    chk(n, 4);
    cgst_host_model_inst.wr(4'h6, 16'h0000);
    step(2);
    ticks(n);
    chk(n, 8);
    cgst_host_model_inst.wr(4'h4, 16'h0000);
    cgst_host_model_inst.wr(4'h5, 16'h0800);
    cgst_host_model_inst.wr(4'h6, 16'h0000);
    step(2);
    n = fine_phase;
    step(1);
    chk(fine_phase, 16'(n + 1));
    // divisor of 5 with both clears set, so the phases restart on each carry
    cgst_host_model_inst.wr(4'h2, 16'h0000);
    cgst_host_model_inst.wr(4'h3, 16'h0005);
    cgst_host_model_inst.wr(4'hD, 16'h7002);
    for (i = 0; i < 40 && leap_carry !== 1'b1; i++) step(1);
    n = 0;
    do begin
      step(1);
      n++;
      if (n == 1) chk({coarse_phase, fine_phase & 16'hFFFE}, 0);
    end while (leap_carry !== 1'b1 && n < 40);
    chk(n, 5);
    cgst_host_model_inst.wr(4'hD, 16'h0002);
    step(20);
    chk(leap_carry, 1'b0);
    end_sim;
  end

  initial begin
    #40000;
    error_cnt++;
    end_sim;
  end
endmodule // cgst_top_test

// file: src/cgst_defines.vh
// Purpose: constants for the channel gain stage and sample-rate timing NCO
// Assumes: host control words are 16 bits, written synchronously to clk
// Notes:   included by every design file of the block
//
// Summary of operation
// RULE1: gain is multiplier stage then shifter stage
// RULE2: multiplier scales data by value over 4096
// RULE3: shift codes 000..111 divide 4096 down to 1
// RULE4: word 0xa holds shift 14:12, multiplier 11:0
// RULE5: sample clock is accumulator msb, paces input
// RULE6: coarse phase steps filter at 4x/8x/16x
// RULE7: fine phase goes to the interpolation filter
// RULE8: 48-bit accumulator adds 48-bit increment per clock
// RULE9: increment split over words 0x4, 0x5, 0x6
// RULE10: quadrant offset from bits 11:10 on output only
// RULE11: leap carry clears coarse, fine or both phases
// RULE12: leap counter gives pre-carry ahead of carry
// RULE13: leap counter runs only while bit 12 set
// RULE14: one carry every N clocks, N the divisor
// RULE15: divisor upper half 0x2, lower half 0x3
// RULE16: host picks divisor at symbol-period multiples
// RULE17: in-phase and quadrature get identical gain
// RULE18: multi-word values take effect coherently together
`ifndef CGST_DEFINES_VH
`define CGST_DEFINES_VH

// ==========================================================
// control word offsets
`define CGST_ADDR_W          4
`define CGST_OFF_DIV_HIGH    4'h2
`define CGST_OFF_DIV_LOW     4'h3
`define CGST_OFF_INC_TOP     4'h4
`define CGST_OFF_INC_MID     4'h5
`define CGST_OFF_INC_BOTTOM  4'h6
`define CGST_OFF_GAIN        4'hA
`define CGST_OFF_FILTER      4'hD

// ==========================================================
// field positions
`define CGST_GAIN_SHIFT_HI   14
`define CGST_GAIN_SHIFT_LO   12
`define CGST_GAIN_MULT_HI    11
`define CGST_GAIN_MULT_LO    0
`define CGST_MULT_FRAC       12
`define CGST_FC_QUAD_HI      11
`define CGST_FC_QUAD_LO      10
`define CGST_FC_LEAP_EN      12
`define CGST_FC_CLR_COARSE   13
`define CGST_FC_CLR_FINE     14
`define CGST_FC_IP_HI        1
`define CGST_FC_IP_LO        0

// ==========================================================
// interpolation factor codes
`define CGST_IP_X4           2'h0
`define CGST_IP_X8           2'h1
`define CGST_IP_X16          2'h2

// ==========================================================
// accumulator layout
`define CGST_ACC_W           48
`define CGST_COARSE_LSB      43
`define CGST_FINE_W          16
`define CGST_LEAP_W          32

// ==========================================================
// reset values
`define CGST_RST_WORD        16'h0000
`define CGST_RST_GAIN        16'h7FFF

`endif

// file: src/cgst_leap_counter.v
// Purpose: fixed-integer leap counter with carry and pre-carry pulses
// Assumes: divisor is stable while enabled; a change reaches the compare at once
// Notes:   divisor 0 behaves as two to the 32nd
`timescale 1ns/1ps
`include "cgst_defines.vh"

module cgst_leap_counter #(
  parameter WIDTH = `CGST_LEAP_W
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // control
  input  wire             enable,
  input  wire [WIDTH-1:0] divisor,
  // events
  output reg              carry,
  output reg              precarry
);

  reg  [WIDTH-1:0] count_reg;
  wire [WIDTH-1:0] last_val = divisor - {{(WIDTH-1){1'b0}}, 1'b1};
  wire [WIDTH-1:0] pre_val  = divisor - {{(WIDTH-2){1'b0}}, 2'b10};
  wire             at_last  = (count_reg == last_val);
  wire             unit_div = (divisor == {{(WIDTH-1){1'b0}}, 1'b1});

  // ==========================================================
  // counting
  always @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= {WIDTH{1'b0}};
      carry     <= 1'b0;
      precarry  <= 1'b0;
    end else if (!enable) begin
      // RULE13: held idle
      count_reg <= {WIDTH{1'b0}};
      carry     <= 1'b0;
      precarry  <= 1'b0;
    end else begin
      // RULE14: carry every N
      carry     <= at_last;
      count_reg <= at_last ? {WIDTH{1'b0}} : count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      // RULE12: pre-carry one ahead
      precarry  <= unit_div | (count_reg == pre_val);
    end
  end

endmodule // cgst_leap_counter

// file: src/cgst_top.v
// Purpose: channel output gain stage and sample-rate NCO with leap counter
// Assumes: host write/read strobes are synchronous to clk
// Notes:   registers read back their last written words; others read zero
`timescale 1ns/1ps
`include "cgst_defines.vh"

module cgst_top #(
  parameter DATA_W = 16,
  parameter ACC_W  = `CGST_ACC_W,
  parameter FINE_W = `CGST_FINE_W
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  sys_rst,
  // host control port
  input  wire [`CGST_ADDR_W-1:0] host_addr,
  input  wire                  host_wr,
  input  wire [15:0]           host_wdata,
  input  wire                  host_rd,
  output reg  [15:0]           host_rdata,
  output reg                   host_rvalid,
  // sample stream in
  input  wire                  din_valid,
  input  wire [DATA_W-1:0]     din_i,
  input  wire [DATA_W-1:0]     din_q,
  // gained stream out
  output reg                   dout_valid,
  output reg  [DATA_W-1:0]     dout_i,
  output reg  [DATA_W-1:0]     dout_q,
  // timing outputs
  output reg                   sample_clk,
  output reg                   sample_tick,
  output reg  [3:0]            coarse_phase,
  output reg                   coarse_tick,
  output reg  [FINE_W-1:0]     fine_phase,
  output reg                   leap_carry,
  output reg                   leap_precarry
);

  // ==========================================================
  // block overview
  // the host writes 16-bit words; multi-word values are staged
  // and only reach the datapath when their last word lands.
  // limitation: writing a low word alone recommits the staged
  // upper words, so software must always write high then low.
  // the gain word takes effect on the next sample; a word that
  // changes mid-stream moves multiplier and shift together.
  // the accumulator never stalls: the quadrant offset is added
  // after it, so phase offset changes cause no frequency error.

  // ==========================================================
  // control registers
  reg  [15:0] div_high_reg;
  reg  [15:0] div_low_reg;
  reg  [15:0] inc_top_reg;
  reg  [15:0] inc_mid_reg;
  reg  [15:0] inc_bottom_reg;
  reg  [15:0] gain_reg;
  reg  [15:0] filter_reg;
  reg  [31:0] leap_divisor_reg;
  reg  [ACC_W-1:0] sample_frequency_increment_reg;

  wire wr_div_high = host_wr & (host_addr == `CGST_OFF_DIV_HIGH);
  wire wr_div_low  = host_wr & (host_addr == `CGST_OFF_DIV_LOW);
  wire wr_inc_top  = host_wr & (host_addr == `CGST_OFF_INC_TOP);
  wire wr_inc_mid  = host_wr & (host_addr == `CGST_OFF_INC_MID);
  wire wr_inc_bot  = host_wr & (host_addr == `CGST_OFF_INC_BOTTOM);
  wire wr_gain     = host_wr & (host_addr == `CGST_OFF_GAIN);
  wire wr_filter   = host_wr & (host_addr == `CGST_OFF_FILTER);

  always @(posedge clk) begin
    if (sys_rst) begin
      div_high_reg   <= `CGST_RST_WORD;
      div_low_reg    <= `CGST_RST_WORD;
      inc_top_reg    <= `CGST_RST_WORD;
      inc_mid_reg    <= `CGST_RST_WORD;
      inc_bottom_reg <= `CGST_RST_WORD;
      gain_reg       <= `CGST_RST_GAIN;
      filter_reg     <= `CGST_RST_WORD;
    end else begin
      // RULE15: divisor halves
      if (wr_div_high) begin
        div_high_reg <= host_wdata;
      end
      if (wr_div_low) begin
        div_low_reg <= host_wdata;
      end

      // RULE9: increment words
      if (wr_inc_top) begin
        inc_top_reg <= host_wdata;
      end
      if (wr_inc_mid) begin
        inc_mid_reg <= host_wdata;
      end
      if (wr_inc_bot) begin
        inc_bottom_reg <= host_wdata;
      end

      // RULE4: gain word
      if (wr_gain) begin
        gain_reg <= host_wdata;
      end

      // filter word: factor, offset, leap enable and clears
      if (wr_filter) begin
        filter_reg <= host_wdata;
      end
    end
  end

  // ==========================================================
  // coherent commit of multi-word values
  // writing the low word commits, so a high word written alone never reaches the datapath
  always @(posedge clk) begin
    if (sys_rst) begin
      leap_divisor_reg               <= {`CGST_LEAP_W{1'b0}};
      sample_frequency_increment_reg <= {ACC_W{1'b0}};
    end else begin
      // RULE18: commit on low word
      // low word data is taken from the bus, not the staging register
      if (wr_div_low) begin
        leap_divisor_reg <= {div_high_reg, host_wdata};
      end
      if (wr_inc_bot) begin
        sample_frequency_increment_reg <= {inc_top_reg, inc_mid_reg, host_wdata};
      end
    end
  end

  // ==========================================================
  // read back
  reg [15:0] rdata_next;

  always @* begin
    case (host_addr)
      `CGST_OFF_DIV_HIGH:   rdata_next = div_high_reg;
      `CGST_OFF_DIV_LOW:    rdata_next = div_low_reg;
      `CGST_OFF_INC_TOP:    rdata_next = inc_top_reg;
      `CGST_OFF_INC_MID:    rdata_next = inc_mid_reg;
      `CGST_OFF_INC_BOTTOM: rdata_next = inc_bottom_reg;
      `CGST_OFF_GAIN:       rdata_next = gain_reg;
      `CGST_OFF_FILTER:     rdata_next = filter_reg;
      default:              rdata_next = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      // data holds between reads so a slow host can still pick it up
      if (host_rd) begin
        host_rdata <= rdata_next;
      end
    end
  end

  // ==========================================================
  // gain stage
  wire [11:0] gain_multiplier = gain_reg[`CGST_GAIN_MULT_HI:`CGST_GAIN_MULT_LO];
  wire [2:0]  gain_shift_code = gain_reg[`CGST_GAIN_SHIFT_HI:`CGST_GAIN_SHIFT_LO];
  reg  [3:0]  shift_amount;

  // RULE3: code to right shift
  always @* begin
    case (gain_shift_code)
      3'h0:    shift_amount = 4'hC;
      3'h1:    shift_amount = 4'h8;
      3'h2:    shift_amount = 4'h5;
      3'h3:    shift_amount = 4'h4;
      3'h4:    shift_amount = 4'h3;
      3'h5:    shift_amount = 4'h2;
      3'h6:    shift_amount = 4'h1;
      default: shift_amount = 4'h0;
    endcase
  end

  reg                valid_s1_reg;
  reg  [3:0]         shift_s1_reg;
  wire [DATA_W-1:0]  din_lane [0:1];
  wire [DATA_W-1:0]  dout_lane_next [0:1];
  reg  [DATA_W-1:0]  scaled_s1_reg [0:1];

  assign din_lane[0] = din_i;
  assign din_lane[1] = din_q;

  // RULE17: same gain both lanes
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
      wire signed [DATA_W+12:0] product =
        $signed(din_lane[lane]) * $signed({1'b0, gain_multiplier});
      // RULE2: divide by 4096
      wire [DATA_W-1:0] scaled =
        product[`CGST_MULT_FRAC+DATA_W-1:`CGST_MULT_FRAC];
      always @(posedge clk) begin
        if (sys_rst) begin
          scaled_s1_reg[lane] <= {DATA_W{1'b0}};
        end else begin
          scaled_s1_reg[lane] <= scaled;
        end
      end
      // RULE1: shifter after multiplier
      assign dout_lane_next[lane] = $signed(scaled_s1_reg[lane]) >>> shift_s1_reg;
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      valid_s1_reg <= 1'b0;
      shift_s1_reg <= 4'h0;
      dout_valid   <= 1'b0;
      dout_i       <= {DATA_W{1'b0}};
      dout_q       <= {DATA_W{1'b0}};
    end else begin
      valid_s1_reg <= din_valid;
      shift_s1_reg <= shift_amount;
      dout_valid   <= valid_s1_reg;
      dout_i       <= dout_lane_next[0];
      dout_q       <= dout_lane_next[1];
    end
  end

  // ==========================================================
  // leap counter
  wire leap_en   = filter_reg[`CGST_FC_LEAP_EN];
  wire carry_raw;
  wire precarry_raw;

  // carry feeds the accumulator raw; the port copy is registered
  // so the clear and the visible pulse line up on the same edge
  cgst_leap_counter #(
    .WIDTH (`CGST_LEAP_W)
  ) cgst_leap_counter_inst (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .enable   (leap_en),
    .divisor  (leap_divisor_reg),
    .carry    (carry_raw),
    .precarry (precarry_raw)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      leap_carry    <= 1'b0;
      leap_precarry <= 1'b0;
    end else begin
      leap_carry    <= carry_raw;
      leap_precarry <= precarry_raw;
    end
  end

  // ==========================================================
  // sample-rate accumulator
  reg  [ACC_W-1:0] acc_reg;
  reg  [ACC_W-1:0] acc_next;
  wire [ACC_W-1:0] acc_sum = acc_reg + sample_frequency_increment_reg;
  wire             clr_coarse = filter_reg[`CGST_FC_CLR_COARSE];
  wire             clr_fine   = filter_reg[`CGST_FC_CLR_FINE];

  always @* begin
    // RULE8: add increment each clock
    acc_next = acc_sum;
    // RULE11: carry clears phases
    // clearing drops this cycle's increment, so the cleared field
    // restarts exactly at zero on the carry edge
    if (carry_raw && clr_coarse) begin
      acc_next[ACC_W-1:`CGST_COARSE_LSB] = {(ACC_W-`CGST_COARSE_LSB){1'b0}};
    end
    if (carry_raw && clr_fine) begin
      acc_next[`CGST_COARSE_LSB-1:0] = {`CGST_COARSE_LSB{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      acc_reg <= {ACC_W{1'b0}};
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ==========================================================
  // phase outputs
  // offset is added on the output side so accumulation is never disturbed
  wire [1:0]       quad_offset = filter_reg[`CGST_FC_QUAD_HI:`CGST_FC_QUAD_LO];
  wire [1:0]       ip_code     = filter_reg[`CGST_FC_IP_HI:`CGST_FC_IP_LO];
  // RULE10: quadrant offset on output
  wire [ACC_W-1:0] phase_out   = acc_reg + {quad_offset, {(ACC_W-2){1'b0}}};
  wire [3:0]       coarse_bits = phase_out[ACC_W-2:ACC_W-5];
  reg  [3:0]       coarse_next;
  reg  [ACC_W-1:0] fine_src;

  // RULE6: coarse width per factor
  always @* begin
    case (ip_code)
      `CGST_IP_X4: begin
        coarse_next = {2'h0, coarse_bits[3:2]};
        fine_src    = phase_out << 3;
      end
      `CGST_IP_X8: begin
        coarse_next = {1'b0, coarse_bits[3:1]};
        fine_src    = phase_out << 4;
      end
      default: begin
        coarse_next = coarse_bits;
        fine_src    = phase_out << 5;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      sample_clk   <= 1'b0;
      sample_tick  <= 1'b0;
      coarse_phase <= 4'h0;
      coarse_tick  <= 1'b0;
      fine_phase   <= {FINE_W{1'b0}};
    end else begin
      // RULE5: msb is sample clock
      sample_clk   <= phase_out[ACC_W-1];
      sample_tick  <= phase_out[ACC_W-1] & ~sample_clk;
      coarse_phase <= coarse_next;
      coarse_tick  <= (coarse_next != coarse_phase);
      // RULE7: fine phase to interpolator
      fine_phase   <= fine_src[ACC_W-1:ACC_W-FINE_W];
    end
  end

endmodule // cgst_top
